/* File: qer_params.svh */
`ifndef QER_PARAMS_SVH
`define QER_PARAMS_SVH

// Register byte offsets
`define QER_OFS_CTRL 12'h000
`define QER_OFS_MUL 12'h004
`define QER_OFS_DIV 12'h008
`define QER_OFS_LINE_SEL 12'h00C
`define QER_OFS_LINE_INFO 12'h010
`define QER_OFS_STATUS 12'h014

// Control register fields
`define QER_CTRL_DIR_BIT 0
`define QER_CTRL_ASEL_BIT 1
`define QER_CTRL_BSEL_LSB 2
`define QER_CTRL_EDGE_BIT 4
`define QER_CTRL_ORDER_BIT 5
`define QER_CTRL_POLICY_BIT 6
`define QER_CTRL_W 7

// Line information fields
`define QER_INFO_DIR_BIT 0
`define QER_INFO_FMT_LSB 1

// Status fields
`define QER_STAT_FWD_BIT 16

// Reset values
`define QER_RST_CTRL 7'h00
`define QER_RST_FACTOR 1
`define QER_RST_LINE_SEL 3'h1

// Reverse backlog ceiling in position mode, and number of lines
`define QER_REV_LIMIT 256
`define QER_LINES 6

`endif

/* File: qer_pkg.sv */
package qer_pkg;

  typedef enum logic [1:0] {
    QER_B_GROUND,
    QER_B_LINE2,
    QER_B_LINE4,
    QER_B_SPARE
  } qer_bsel_t;

  typedef enum logic {
    QER_EDGE_RISE_ONLY,
    QER_EDGE_BOTH
  } qer_edge_t;

  typedef enum logic {
    QER_SCALE_MUL_FIRST,
    QER_SCALE_DIV_FIRST
  } qer_order_t;

  typedef enum logic {
    QER_POLICY_POSITION,
    QER_POLICY_MOTION
  } qer_policy_t;

  typedef enum logic [1:0] {
    QER_FMT_SINGLE_ENDED,
    QER_FMT_OPEN_COLLECTOR,
    QER_FMT_RS422,
    QER_FMT_RESERVED
  } qer_format_t;

endpackage : qer_pkg

/* File: qer_encoder.sv */
// What this block does
// - Clockwise setting: phase B leading phase A counts as forward motion.
// - Counter-clockwise setting: phase A leading phase B counts as forward motion.
// - Phase A comes from line 1 or line 3, chosen by software.
// - Phase B comes from line 2, line 4, or ground meaning unused.
// - Count rising edges only, or both edges, as configured.
// - Rescaler multiplies then divides, or divides then multiplies, as configured.
// - Output pulse rate is multiplied by a programmable integer factor.
// - Output pulse rate is divided by a programmable integer factor.
// - A line index 1 to 6 selects which line reports apply to.
// - Selected line reports read-only whether it is input or output.
// - Selected line reports read-only format: single-ended, open-collector or RS422.
// - Motion mode: trigger on every increment in either direction.
// - Position mode: reverse saturates at 256, same forward count then suppressed.
`timescale 1ns/100ps
`include "qer_params.svh"

module qer_encoder #(
  parameter int SCALE_W = 8,
  parameter int PEND_W = 16,
  parameter logic [5:0] LINE_OUT_MASK = 6'h30,
  parameter logic [11:0] LINE_FORMATS = 12'h500
) (
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic CLK_EN,
  input wire logic [5:0] LINE_IN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic ENC_TRIGGER,
  output logic ENC_FORWARD
);

  if (SCALE_W < 1 || SCALE_W > 16 || PEND_W < SCALE_W + 1 || PEND_W > 24)
  begin : g_bad_params
    $error("qer_encoder: unsupported SCALE_W or PEND_W");
  end

  localparam int REV_W = 9;
  localparam logic [REV_W-1:0] REV_MAX = REV_W'(`QER_REV_LIMIT);

  // Configuration registers
  logic encoder_forward_phase_select;
  logic phase_a_line_select;
  qer_pkg::qer_bsel_t phase_b_line_select;
  qer_pkg::qer_edge_t count_edge_select;
  qer_pkg::qer_order_t scale_order_select;
  qer_pkg::qer_policy_t encoder_trigger_policy;
  logic [SCALE_W-1:0] pulse_mul_factor;
  logic [SCALE_W-1:0] pulse_div_factor;
  logic [2:0] io_line_index;

  // Bus decode
  logic setup;
  logic commit_wr;
  logic addr_ok;
  logic [31:0] read_word;
  logic [`QER_CTRL_W-1:0] ctrl_word;
  logic io_direction_report;
  logic [1:0] io_electrical_kind;
  logic [2:0] line_pos;

  // Decoder
  logic [5:0] line_meta;
  logic [5:0] line_sync;
  logic phase_a;
  logic phase_a_prev;
  logic phase_a_valid;
  logic phase_b;
  logic phase_b_used;
  logic a_rise;
  logic a_fall;
  logic step;
  logic a_leads;
  logic forward;
  logic [1:0] sync_warm;

  // Position tracking and rescaler
  logic [REV_W-1:0] rev_backlog;
  logic passed;
  logic [PEND_W-1:0] pend;
  logic [SCALE_W-1:0] div_count;
  logic mul_in;
  logic mul_out;
  logic div_in;
  logic div_out;
  logic scaled;
  logic div_first;
  logic [SCALE_W-1:0] mul_eff;
  logic [SCALE_W-1:0] div_eff;
  logic [PEND_W:0] next_pend_sum;
  logic [PEND_W-1:0] next_pend;

  assign setup = PSEL && !PENABLE && !PREADY;
  assign commit_wr = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
  assign ctrl_word = {encoder_trigger_policy, scale_order_select, count_edge_select,
                      phase_b_line_select, phase_a_line_select, encoder_forward_phase_select};

  // Report the line picked by the index
  assign line_pos = io_line_index - 3'h1;
  assign io_direction_report = LINE_OUT_MASK[line_pos];
  assign io_electrical_kind = LINE_FORMATS[{line_pos, 1'b0} +: 2];

  always_comb
  begin
    read_word = 32'h00000000;
    addr_ok = 1'b1;
    case (PADDR)
      `QER_OFS_CTRL: read_word[`QER_CTRL_W-1:0] = ctrl_word;
      `QER_OFS_MUL: read_word[SCALE_W-1:0] = pulse_mul_factor;
      `QER_OFS_DIV: read_word[SCALE_W-1:0] = pulse_div_factor;
      `QER_OFS_LINE_SEL: read_word[2:0] = io_line_index;
      `QER_OFS_LINE_INFO:
      begin
        read_word[`QER_INFO_DIR_BIT] = io_direction_report;
        read_word[`QER_INFO_FMT_LSB +: 2] = io_electrical_kind;
      end
      `QER_OFS_STATUS:
      begin
        read_word[REV_W-1:0] = rev_backlog;
        read_word[`QER_STAT_FWD_BIT] = ENC_FORWARD;
      end
      default: addr_ok = 1'b0;
    endcase
    // Index outside 1..6 is refused so reports never point past the lines
    if (PWRITE && PADDR == `QER_OFS_LINE_SEL &&
        (PWDATA[2:0] == 3'h0 || PWDATA[2:0] > 3'(`QER_LINES) || PWDATA[31:3] != 29'h0))
      addr_ok = 1'b0;
  end

  // Answer in the cycle after setup, data and error registered
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      PREADY <= 1'b0;
      PRDATA <= 32'h00000000;
      PSLVERR <= 1'b0;
    end
    else if (CLK_EN)
    begin
      PREADY <= setup;
      if (setup)
      begin
        PRDATA <= PWRITE ? 32'h00000000 : read_word;
        PSLVERR <= !addr_ok;
      end
      else
      begin
        PSLVERR <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      encoder_forward_phase_select <= 1'b0;
      phase_a_line_select <= 1'b0;
      phase_b_line_select <= qer_pkg::QER_B_GROUND;
      count_edge_select <= qer_pkg::QER_EDGE_RISE_ONLY;
      scale_order_select <= qer_pkg::QER_SCALE_MUL_FIRST;
      encoder_trigger_policy <= qer_pkg::QER_POLICY_POSITION;
      pulse_mul_factor <= SCALE_W'(`QER_RST_FACTOR);
      pulse_div_factor <= SCALE_W'(`QER_RST_FACTOR);
      io_line_index <= `QER_RST_LINE_SEL;
    end
    else if (CLK_EN && commit_wr)
    begin
      case (PADDR)
        `QER_OFS_CTRL:
        begin
          encoder_forward_phase_select <= PWDATA[`QER_CTRL_DIR_BIT];
          phase_a_line_select <= PWDATA[`QER_CTRL_ASEL_BIT];
          phase_b_line_select <= qer_pkg::qer_bsel_t'(PWDATA[`QER_CTRL_BSEL_LSB +: 2]);
          count_edge_select <= qer_pkg::qer_edge_t'(PWDATA[`QER_CTRL_EDGE_BIT]);
          scale_order_select <= qer_pkg::qer_order_t'(PWDATA[`QER_CTRL_ORDER_BIT]);
          encoder_trigger_policy <= qer_pkg::qer_policy_t'(PWDATA[`QER_CTRL_POLICY_BIT]);
        end
        `QER_OFS_MUL: pulse_mul_factor <= PWDATA[SCALE_W-1:0];
        `QER_OFS_DIV: pulse_div_factor <= PWDATA[SCALE_W-1:0];
        `QER_OFS_LINE_SEL: io_line_index <= PWDATA[2:0];
        default: ;
      endcase
    end
  end

  // Two-stage synchroniser on every line
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      line_meta <= 6'h00;
      line_sync <= 6'h00;
    end
    else if (CLK_EN)
    begin
      line_meta <= LINE_IN;
      line_sync <= line_meta;
    end
  end

  // A line strapped as output is never a valid phase source
  always_comb
  begin
    phase_a = phase_a_line_select ? line_sync[2] : line_sync[0];
    phase_a_valid = phase_a_line_select ? !LINE_OUT_MASK[2] : !LINE_OUT_MASK[0];
    case (phase_b_line_select)
      qer_pkg::QER_B_LINE2:
      begin
        phase_b = line_sync[1];
        phase_b_used = !LINE_OUT_MASK[1];
      end
      qer_pkg::QER_B_LINE4:
      begin
        phase_b = line_sync[3];
        phase_b_used = !LINE_OUT_MASK[3];
      end
      default:
      begin
        phase_b = 1'b0;
        phase_b_used = 1'b0;
      end
    endcase
  end

  assign a_rise = phase_a_valid && phase_a && !phase_a_prev;
  assign a_fall = phase_a_valid && !phase_a && phase_a_prev;
  // No steps until sync and edge history hold real line levels
  assign step = (sync_warm == 2'h3) &&
                (a_rise || (count_edge_select == qer_pkg::QER_EDGE_BOTH && a_fall));
  // A rising while B low, or A falling while B high, means A leads
  assign a_leads = a_rise ? !phase_b : phase_b;
  // Without phase B every step is taken as forward
  assign forward = !phase_b_used ||
                   (a_leads == encoder_forward_phase_select);

  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      phase_a_prev <= 1'b0;
      sync_warm <= 2'h0;
      ENC_FORWARD <= 1'b1;
    end
    else if (CLK_EN)
    begin
      phase_a_prev <= phase_a;
      if (sync_warm != 2'h3)
        sync_warm <= sync_warm + 2'h1;
      if (step)
        ENC_FORWARD <= forward;
    end
  end

  // Reverse backlog: saturates, cleared only by reset, paid back by forward steps
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
      rev_backlog <= '0;
    else if (CLK_EN && step && encoder_trigger_policy == qer_pkg::QER_POLICY_POSITION)
    begin
      if (!forward && rev_backlog != REV_MAX)
        rev_backlog <= rev_backlog + REV_W'(1);
      else if (forward && rev_backlog != '0)
        rev_backlog <= rev_backlog - REV_W'(1);
    end
  end

  always_comb
  begin
    if (encoder_trigger_policy == qer_pkg::QER_POLICY_MOTION)
      passed = step;
    else
      passed = step && forward && rev_backlog == '0;
  end

  // Zero factors behave as one so the pulse stream never stops dead
  assign mul_eff = (pulse_mul_factor == '0) ? SCALE_W'(1) : pulse_mul_factor;
  assign div_eff = (pulse_div_factor == '0) ? SCALE_W'(1) : pulse_div_factor;

  // One rescaler chain, stage order swapped by muxes
  assign div_first = (scale_order_select == qer_pkg::QER_SCALE_DIV_FIRST);
  assign mul_in = div_first ? div_out : passed;
  assign div_in = div_first ? passed : mul_out;
  assign scaled = div_first ? mul_out : div_out;

  // Multiplier: each input adds factor pulses, drained one per cycle
  assign mul_out = (pend != '0);
  always_comb
  begin
    next_pend_sum = {1'b0, pend} - {{PEND_W{1'b0}}, mul_out};
    if (mul_in)
      next_pend_sum = next_pend_sum + (PEND_W+1)'(mul_eff);
    // Saturate rather than wrap if pulses arrive faster than they drain
    next_pend = next_pend_sum[PEND_W] ? '1 : next_pend_sum[PEND_W-1:0];
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
      pend <= '0;
    else if (CLK_EN)
      pend <= next_pend;
  end

  // Divider: one pulse out per factor pulses in
  assign div_out = div_in && (div_count + SCALE_W'(1) >= div_eff);

  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
      div_count <= '0;
    else if (CLK_EN && div_in)
      div_count <= div_out ? '0 : div_count + SCALE_W'(1);
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
      ENC_TRIGGER <= 1'b0;
    else if (CLK_EN)
      ENC_TRIGGER <= scaled;
  end

endmodule : qer_encoder

/* File: qer_encoder_props.sv */
`timescale 1ns/100ps
module qer_encoder_props (
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic CLK_EN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic ENC_TRIGGER,
  input wire logic ENC_FORWARD
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESET_N);
  sequence setup_s;
    PSEL && !PENABLE && !PREADY && CLK_EN;
  endsequence
  sequence bad_sel_s;
    setup_s ##0 (PWRITE && PADDR == 12'h00C && (PWDATA == 32'h0 || PWDATA > 32'h6));
  endsequence
  AST_READY_NEXT: assert property (setup_s |=> PREADY) else $error("ready late");
  AST_READY_PULSE: assert property (PREADY |=> !PREADY) else $error("ready held");
  AST_READY_IDLE: assert property (!PSEL |=> !PREADY) else $error("ready unasked");
  AST_ERR_READY: assert property (PSLVERR |-> PREADY) else $error("stray error");
  AST_UNMAPPED: assert property (setup_s ##0 (PADDR > 12'h014 || PADDR[1:0] != 2'h0)
    |=> PSLVERR) else $error("unmapped accepted");
  AST_LINE_SEL_ERR: assert property (bad_sel_s |=> PSLVERR)
    else $error("bad line index accepted");
  AST_INFO_OK: assert property (setup_s ##0
    (PADDR == 12'h010 || PADDR == 12'h014) |=> !PSLVERR) else $error("report access refused");
  AST_RESET_QUIET: assert property ($rose(RESET_N) |-> !ENC_TRIGGER [*3])
    else $error("trigger before sync");
  AST_FWD_RESET: assert property ($rose(RESET_N) |-> ENC_FORWARD) else $error("direction reset");
endmodule : qer_encoder_props

bind qer_encoder qer_encoder_props u_props (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N),
  .CLK_EN(CLK_EN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .ENC_TRIGGER(ENC_TRIGGER),
  .ENC_FORWARD(ENC_FORWARD));

/* File: qer_shaft_model.sv */
`timescale 1ns/100ps
module qer_shaft_model (
  input wire logic clk,
  output logic pha,
  output logic phb
);
  logic [1:0] quarter = 2'h0;
  // Gray order: only one phase moves per quarter
  assign pha = quarter == 2'h1 || quarter == 2'h2;
  assign phb = quarter[1];
  task automatic turn(input bit a_lead, input int cycles);
    repeat (cycles * 4)
    begin
      quarter <= a_lead ? quarter + 2'h1 : quarter - 2'h1;
      // Four clocks per level, above the decoder's minimum of one
      repeat (4) @(posedge clk);
    end
  endtask : turn
endmodule : qer_shaft_model

/* File: quadrature_encoder_rescaler_tb_top.sv */
`timescale 1ns/100ps
`define QER_CHECK(got, exp) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) \
    begin \
      miscompares++; \
      $display("ERROR t=%0t got %0h exp %0h", $time, got, exp); \
    end \
  end
module quadrature_encoder_rescaler_tb_top;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic route3 = 1'b0;
  logic clk_en = 1'b1;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic enc_trigger;
  logic enc_forward;
  logic pha;
  logic phb;
  logic [5:0] line_in;
  int miscompares = 0;
  int checks_done = 0;
  int trig_cnt = 0;
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
    if (enc_trigger === 1'b1)
      trig_cnt <= trig_cnt + 1;
  // Phases only on lines 1 to 4, which are inputs
  assign line_in = route3 ? {2'h0, phb, pha, 2'h0} : {4'h0, phb, pha};
  qer_shaft_model u_shaft (.clk(clk_sys), .pha(pha), .phb(phb));
  qer_encoder dut (.CLK_SYS(clk_sys), .RESET_N(reset_n), .CLK_EN(clk_en), .LINE_IN(line_in),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .ENC_TRIGGER(enc_trigger),
    .ENC_FORWARD(enc_forward));
  task automatic summarize;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] w,
    output logic [31:0] d, output logic e);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= w;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so the next call never reassigns psel in this step
    @(posedge clk_sys);
    if (n >= 20)
    begin
      miscompares++;
      summarize();
    end
  endtask : apb
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] d;
    logic e;
    apb(1'b0, a, 32'h0, d, e);
    `QER_CHECK(d, x)
    `QER_CHECK(e, xe)
  endtask : rd_chk
  task automatic wr_chk(input logic [11:0] a, input logic [31:0] w, input logic xe);
    logic [31:0] d;
    logic e;
    apb(1'b1, a, w, d, e);
    `QER_CHECK(e, xe)
  endtask : wr_chk
  task automatic run(input logic [6:0] ctrl, input logic [7:0] mul, input logic [7:0] dv,
    input bit a_lead, input int cyc, input int xt, input logic xf);
    int base;
    wr_chk(12'h000, {25'h0, ctrl}, 1'b0);
    wr_chk(12'h004, {24'h0, mul}, 1'b0);
    wr_chk(12'h008, {24'h0, dv}, 1'b0);
    base = trig_cnt;
    u_shaft.turn(a_lead, cyc);
    repeat (12) @(posedge clk_sys);
    `QER_CHECK(trig_cnt - base, xt)
    `QER_CHECK(enc_forward, xf)
  endtask : run
  task automatic t_regs;
    rd_chk(12'h000, 32'h0, 1'b0);
    rd_chk(12'h004, 32'h1, 1'b0);
    rd_chk(12'h008, 32'h1, 1'b0);
    rd_chk(12'h00C, 32'h1, 1'b0);
    rd_chk(12'h018, 32'h0, 1'b1);
    wr_chk(12'h102, 32'h5, 1'b1);
  endtask : t_regs
  task automatic t_lines;
    for (int i = 1; i <= 6; i++)
    begin
      wr_chk(12'h00C, i, 1'b0);
      rd_chk(12'h010, (i >= 5) ? 32'h3 : 32'h0, 1'b0);
    end
    wr_chk(12'h00C, 32'h0, 1'b1);
    wr_chk(12'h00C, 32'h7, 1'b1);
    wr_chk(12'h00C, 32'h9, 1'b1);
    wr_chk(12'h010, 32'h0, 1'b0);
    rd_chk(12'h00C, 32'h6, 1'b0);
    rd_chk(12'h010, 32'h3, 1'b0);
  endtask : t_lines
  task automatic t_motion;
    run(7'h45, 8'h1, 8'h1, 1, 1, 1, 1'b1);
    run(7'h55, 8'h1, 8'h1, 1, 1, 2, 1'b1);
    run(7'h44, 8'h1, 8'h1, 1, 1, 1, 1'b0);
    run(7'h44, 8'h1, 8'h1, 0, 1, 1, 1'b1);
    run(7'h41, 8'h1, 8'h1, 0, 1, 1, 1'b1);
    run(7'h4D, 8'h1, 8'h1, 0, 1, 1, 1'b1);
  endtask : t_motion
  task automatic t_scale;
    run(7'h45, 8'h3, 8'h1, 1, 1, 3, 1'b1);
    run(7'h45, 8'h1, 8'h3, 1, 3, 1, 1'b1);
    run(7'h45, 8'h2, 8'h2, 1, 1, 1, 1'b1);
    run(7'h65, 8'h2, 8'h2, 1, 1, 0, 1'b1);
    run(7'h65, 8'h2, 8'h2, 1, 1, 2, 1'b1);
    run(7'h45, 8'h0, 8'h0, 1, 1, 1, 1'b1);
  endtask : t_scale
  task automatic t_route;
    route3 <= 1'b1;
    run(7'h45, 8'h1, 8'h1, 1, 1, 0, 1'b1);
    run(7'h4B, 8'h1, 8'h1, 1, 1, 1, 1'b1);
    route3 <= 1'b0;
  endtask : t_route
  task automatic t_position;
    // Overshoot past the ceiling to prove the backlog saturates
    run(7'h05, 8'h1, 8'h1, 0, 258, 0, 1'b0);
    rd_chk(12'h014, 32'h0000_0100, 1'b0);
    run(7'h05, 8'h1, 8'h1, 1, 256, 0, 1'b1);
    rd_chk(12'h014, 32'h0001_0000, 1'b0);
    run(7'h05, 8'h1, 8'h1, 1, 1, 1, 1'b1);
  endtask : t_position
  task automatic t_freeze;
    int base;
    // Position mode, no backlog: a live turn would give one trigger
    clk_en <= 1'b0;
    base = trig_cnt;
    u_shaft.turn(1, 1);
    repeat (12) @(posedge clk_sys);
    clk_en <= 1'b1;
    repeat (12) @(posedge clk_sys);
    `QER_CHECK(trig_cnt - base, 0)
  endtask : t_freeze
  initial
  begin
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    t_regs();
    t_lines();
    t_motion();
    t_scale();
    t_route();
    t_position();
    t_freeze();
    summarize();
  end
endmodule : quadrature_encoder_rescaler_tb_top
